// ### include/led_ctrl_params.svh
`ifndef LED_CTRL_PARAMS_SVH
`define LED_CTRL_PARAMS_SVH

// clock period in ns
`define CLK_PERIOD_NS       10
// glitch filter width, ns
`define DEGLITCH_NS         80
`define DEGLITCH_CYC        ((`DEGLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// start delay, us; fires after typical 350, well below 450 max
`define START_DELAY_US      350
`define START_DELAY_CYC     ((`START_DELAY_US * 1000) / `CLK_PERIOD_NS)
// shutdown delay window 0.5..2.5 ms; target 1.5 ms
`define SHDN_MIN_US         500
`define SHDN_MAX_US         2500
`define SHDN_CYC            (((`SHDN_MIN_US + `SHDN_MAX_US) / 2 * 1000) / `CLK_PERIOD_NS)
// soft-start total time, us, in equal steps
`define RAMP_TIME_US        200
`define RAMP_STEPS          8
`define RAMP_STEP_CYC       ((`RAMP_TIME_US * 1000) / `CLK_PERIOD_NS / `RAMP_STEPS)
// current step in microamps
`define STEP_CURRENT_UA     12500
`define SHORT_SENSE_UA      2500
`define LEVEL_OFFSET        17

`endif

// ### include/led_ctrl_pkg.sv
package led_ctrl_pkg;
  // main operating states
  typedef enum logic [1:0] {
    ST_SHDN,
    ST_WAIT,
    ST_RAMP,
    ST_ON
  } mode_t;
  // why the output is currently gated
  typedef enum logic [1:0] {
    OUT_OFF,
    OUT_SENSE,
    OUT_DRIVE
  } drive_t;
endpackage

// ### design/pin_deglitch.sv
`timescale 1ns/1ns
`default_nettype none
`include "led_ctrl_params.svh"

// two-flop synchroniser then a stability filter of FILT_CYC cycles
module pin_deglitch #(
  parameter int FILT_CYC = `DEGLITCH_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic pinAsync,
  output var  logic pinClean
);
  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic [7:0] cnt;
    logic       clean;
  } flt_t;

  flt_t s_r;
  flt_t s_nxt;

  // counter restarts whenever the synced level agrees with output
  always_comb begin
    s_nxt       = s_r;
    s_nxt.sync1 = pinAsync;
    s_nxt.sync2 = s_r.sync1;
    if (s_r.sync2 == s_r.clean) begin
      s_nxt.cnt = 8'h00;
    end else if (s_r.cnt >= 8'(FILT_CYC - 1)) begin
      s_nxt.cnt   = 8'h00;
      s_nxt.clean = s_r.sync2;
    end else begin
      s_nxt.cnt = s_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pinClean = s_r.clean;
endmodule
`default_nettype wire

// ### design/pulse_count_led_current_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "led_ctrl_params.svh"

// Contract
// - pin high keeps block active and output able to sink current
// - pin low beyond shutdown delay turns everything off
// - shutdown delay lies between 0.5 ms and 2.5 ms
// - pin glitches under 80 ns are ignored
// - start ramps to target in 8 equal steps over about 200 us
// - undervoltage gates output; clearing restores held level
// - short detection armed only after first ramp step
// - during short, drive only the 2.5 mA sensing current
// - short clearing restores programmed current automatically
// - over-temperature disables output and latches it
// - resume after thermal trip needs temp clear and pin reset
// - rising edges counted into a 4-bit step code
// - ramp begins after pin stays high past start delay
// - edges after ramp step current at once, no new ramp
// - current is 12.5 mA times (17 minus edge count)
// - edge count wraps modulo 16
module pulse_count_led_current_ctrl
  import led_ctrl_pkg::*;
#(
  parameter int START_CYC = `START_DELAY_CYC,
  parameter int SHDN_CYC  = `SHDN_CYC,
  parameter int STEP_CYC  = `RAMP_STEP_CYC,
  parameter int FILT_CYC  = `DEGLITCH_CYC
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 ctrlPin,
  input  wire logic                 underVoltage,
  input  wire logic                 overTemp,
  input  wire logic                 ledShort,
  output var  logic                 activeOn,
  output var  logic [3:0]           stepCode,
  output var  logic [3:0]           rampStep,
  output var  logic [7:0]           currentLevel,
  output var  logic                 senseOn,
  output var  logic                 thermalTrip,
  output var  led_ctrl_pkg::drive_t driveMode
);
  import led_ctrl_pkg::*;

  // ****************************************************************
  // fault input synchronisers and types
  // ****************************************************************
  typedef struct packed {
    mode_t       mode;
    logic        pinPrev;
    logic [3:0]  edgeCnt;
    logic [23:0] tmr;
    logic [23:0] lowTmr;
    logic [3:0]  ramp;
    logic        shortArm;
    logic        thermLatch;
    logic [2:0]  uvSync;
    logic [2:0]  otSync;
    logic [2:0]  scSync;
    logic        active;
    logic [3:0]  code;
    logic [7:0]  level;
    logic        sense;
    drive_t      drive;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic   pinClean;

  // ****************************************************************
  // pin filter
  // ****************************************************************
  // glitch filter
  pin_deglitch #(
    .FILT_CYC (FILT_CYC)
  ) u_deglitch (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .pinAsync (ctrlPin),
    .pinClean (pinClean)
  );

  // ****************************************************************
  // control logic
  // ****************************************************************
  logic       riseEdge;
  logic       uvS;
  logic       otS;
  logic       scS;
  logic [4:0] target;
  logic [8:0] scaled;

  // sync flags are bit 1 of each chain; bit 0 feeds only bit 1
  assign uvS      = s_r.uvSync[1];
  assign otS      = s_r.otSync[1];
  assign scS      = s_r.scSync[1];
  assign riseEdge = pinClean & ~s_r.pinPrev;

  // one process computes the whole next state
  always_comb begin
    s_nxt         = s_r;
    s_nxt.pinPrev = pinClean;
    s_nxt.uvSync  = {1'b0, s_r.uvSync[0], underVoltage};
    s_nxt.otSync  = {1'b0, s_r.otSync[0], overTemp};
    s_nxt.scSync  = {1'b0, s_r.scSync[0], ledShort};
    target        = 5'h00;
    scaled        = 9'h000;

    if (pinClean) begin
      s_nxt.lowTmr = 24'h000000;
    end else if (s_r.mode != ST_SHDN) begin
      s_nxt.lowTmr = s_r.lowTmr + 24'h000001;
    end

    if (riseEdge) begin
      s_nxt.edgeCnt = s_r.edgeCnt + 4'h1;
    end

    case (s_r.mode)
      ST_SHDN: begin
        if (riseEdge) begin
          s_nxt.mode = ST_WAIT;
          s_nxt.tmr  = 24'h000000;
        end
      end
      ST_WAIT: begin
        // start delay, restarted by any edge or low level
        if (!pinClean || riseEdge) begin
          s_nxt.tmr = 24'h000000;
        end else if (s_r.tmr >= 24'(START_CYC - 1)) begin
          s_nxt.mode = ST_RAMP;
          s_nxt.tmr  = 24'h000000;
          s_nxt.ramp = 4'h1;
        end else begin
          s_nxt.tmr = s_r.tmr + 24'h000001;
        end
      end
      ST_RAMP: begin
        if (s_r.tmr >= 24'(STEP_CYC - 1)) begin
          s_nxt.tmr = 24'h000000;
          s_nxt.shortArm = 1'b1;
          if (s_r.ramp >= 4'(`RAMP_STEPS)) begin
            s_nxt.mode = ST_ON;
          end else begin
            s_nxt.ramp = s_r.ramp + 4'h1;
          end
        end else begin
          s_nxt.tmr = s_r.tmr + 24'h000001;
        end
      end
      ST_ON: begin
        // edges take effect directly via code below
        s_nxt.tmr = 24'h000000;
      end
      default: begin
        s_nxt.mode = ST_SHDN;
      end
    endcase

    if (otS && s_r.mode != ST_SHDN) begin
      s_nxt.thermLatch = 1'b1;
    end

    // shutdown after low delay; clears state
    if (s_r.mode != ST_SHDN && !pinClean && s_r.lowTmr >= 24'(SHDN_CYC - 1)) begin
      s_nxt.mode       = ST_SHDN;
      s_nxt.edgeCnt    = 4'h0;
      s_nxt.ramp       = 4'h0;
      s_nxt.tmr        = 24'h000000;
      s_nxt.lowTmr     = 24'h000000;
      s_nxt.shortArm   = 1'b0;
      s_nxt.thermLatch = otS;
    end

    // level = 17 - n in 12.5 mA units, n = 16 when count wraps to 0
    s_nxt.code = s_nxt.edgeCnt;
    target     = 5'(`LEVEL_OFFSET) - ((s_nxt.edgeCnt == 4'h0) ? 5'h10 : {1'b0, s_nxt.edgeCnt});
    scaled     = 9'(target) * 9'(s_nxt.ramp);
    s_nxt.active = (s_nxt.mode != ST_SHDN);

    if (s_nxt.mode != ST_RAMP && s_nxt.mode != ST_ON) begin
      s_nxt.drive = OUT_OFF;
      s_nxt.level = 8'h00;
      s_nxt.sense = 1'b0;
    end else if (uvS || s_nxt.thermLatch) begin
      s_nxt.drive = OUT_OFF;
      s_nxt.level = 8'h00;
      s_nxt.sense = 1'b0;
    end else if (s_nxt.shortArm && scS) begin
      s_nxt.drive = OUT_SENSE;
      s_nxt.level = 8'h00;
      s_nxt.sense = 1'b1;
    end else begin
      s_nxt.drive = OUT_DRIVE;
      s_nxt.sense = 1'b0;
      // level in 12.5 mA/8 units during ramp, scaled so step 8 = full
      s_nxt.level = (s_nxt.mode == ST_ON) ? {target, 3'b000} : scaled[7:0];
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_r      <= '0;
      s_r.mode <= ST_SHDN;
      s_r.drive <= OUT_OFF;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from state flops
  assign activeOn     = s_r.active;
  assign stepCode     = s_r.code;
  assign rampStep     = s_r.ramp;
  assign currentLevel = s_r.level;
  assign senseOn      = s_r.sense;
  assign thermalTrip  = s_r.thermLatch;
  assign driveMode    = s_r.drive;
endmodule
`default_nettype wire

// ### test/led_ctrl_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ****************
// output checker
// ****************
module led_ctrl_monitor
  import led_ctrl_pkg::*;
#(
  parameter int SHDN_CYC  = 200,
  parameter int START_CYC = 50
) (
  input wire logic                 clk_sys,
  input wire logic                 rst_n,
  input wire logic                 ctrlPin,
  input wire logic                 underVoltage,
  input wire logic                 activeOn,
  input wire logic [3:0]           stepCode,
  input wire logic [3:0]           rampStep,
  input wire logic [7:0]           currentLevel,
  input wire logic                 senseOn,
  input wire logic                 thermalTrip,
  input wire led_ctrl_pkg::drive_t driveMode
);
  logic [15:0] hiRun_r;
  logic [15:0] loRun_r;
  logic [7:0]  fullLvl;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // raw pin run lengths; saturate so long holds never wrap
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hiRun_r <= '0;
      loRun_r <= '0;
    end else begin
      hiRun_r <= ctrlPin ? hiRun_r + 16'(hiRun_r != '1) : '0;
      loRun_r <= ctrlPin ? '0 : loRun_r + 16'(loRun_r != '1);
    end
  end
  // settled level; code 0 stands for sixteen edges
  assign fullLvl = (8'h11 - {3'h0, stepCode == 4'h0, stepCode}) << 3;
  a_high_keeps_on: assert property (hiRun_r > 16'd20 |-> activeOn)
    else $error("inactive while pin high");
  a_shdn_not_late: assert property (loRun_r > SHDN_CYC + 16 |-> !activeOn)
    else $error("shutdown missed");
  a_shdn_not_early: assert property ($fell(activeOn) |-> loRun_r >= SHDN_CYC)
    else $error("shutdown too early");
  a_start_delay: assert property ($changed(rampStep) && rampStep == 4'h1 |-> hiRun_r >= START_CYC)
    else $error("ramp began early");
  a_ramp_order: assert property ($changed(rampStep) && rampStep != 4'h0 |->
    rampStep == $past(rampStep) + 4'h1 && rampStep <= 4'h8)
    else $error("ramp step skipped");
  a_full_level: assert property (driveMode == OUT_DRIVE && rampStep == 4'h8 |-> currentLevel == fullLvl)
    else $error("wrong level");
  a_short_armed: assert property (rampStep == 4'h0 |-> !senseOn)
    else $error("short seen before ramp");
  a_sense_gates: assert property (senseOn |-> driveMode == OUT_SENSE && currentLevel == 8'h00)
    else $error("drive during short");
  a_trip_latch: assert property (thermalTrip ##1 activeOn |-> thermalTrip && driveMode == OUT_OFF)
    else $error("thermal latch lost");
  a_uv_blanks: assert property (underVoltage [*5] |-> driveMode == OUT_OFF)
    else $error("drive during undervoltage");
endmodule
`default_nettype wire

// ### test/host_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************
// host pin driver
// ****************
module host_pin_model (
  input  wire logic clk_sys,
  output var  logic ctrlPin
);
  // pin idles low like the internal pull-down
  initial ctrlPin = 1'b0;
  // level for n cycles; called just after an edge
  task automatic drive(input logic v, input int n);
    ctrlPin = v;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // widths kept legal, pin left high
  task automatic pulses(input int n, input int hi, input int lo);
    for (int i = 0; i < n; i++) begin
      drive(1'b0, lo);
      drive(1'b1, (i == n - 1) ? 1 : hi);
    end
  endtask
endmodule
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ns
`default_nettype none
// ****************
// bench top
// ****************
module tb;
  import led_ctrl_pkg::*;
  localparam int ST = 50;
  localparam int SD = 200;
  localparam int SC = 10;
  logic clk_sys = 1'b0, rst_n = 1'b0, underVoltage = 1'b0, overTemp = 1'b0, ledShort = 1'b0;
  logic ctrlPin, activeOn, senseOn, thermalTrip;
  logic [3:0] stepCode, rampStep;
  logic [7:0] currentLevel;
  drive_t     driveMode;
  int         miscompares = 0, check_count = 0, n;
  always #5 clk_sys = ~clk_sys;
  host_pin_model host_u (.clk_sys, .ctrlPin);
  pulse_count_led_current_ctrl #(.START_CYC(ST), .SHDN_CYC(SD), .STEP_CYC(SC)) dut_u (
    .clk_sys, .rst_n, .ctrlPin, .underVoltage, .overTemp, .ledShort, .activeOn,
    .stepCode, .rampStep, .currentLevel, .senseOn, .thermalTrip, .driveMode);
  // wait, then land just after the edge
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] lvl(input int k);
    return 8'((17 - ((k - 1) % 16 + 1)) * 8);
  endfunction
  task automatic chkOn(input int k);
    chk({4'h0, stepCode}, 8'(k % 16));
    chk(currentLevel, lvl(k));
    chk({4'h0, rampStep}, 8'h08);
    chk(8'(driveMode), 8'(OUT_DRIVE));
  endtask
  task automatic summarize();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // hang guard, well past the whole sequence
  initial begin
    #500000;
    miscompares++;
    summarize();
  end
  initial begin
    void'($urandom(25));
    cyc(5);
    rst_n = 1'b1;
    // edge counts: wrap, sixteen, random
    for (int t = 0; t < 3; t++) begin
      n = (t == 0) ? 17 : (t == 1) ? 16 : 1 + $urandom % 15;
      // widths stay well under the start delay, as real pulses do
      host_u.pulses(n, 20 + $urandom % 20, 20 + $urandom % 20);
      ledShort = 1'b1;
      cyc(20);
      chk({7'h00, senseOn}, 8'h00);
      ledShort = 1'b0;
      cyc(ST + 8 * SC + 40);
      chkOn(n);
      host_u.drive(1'b0, SD - 20);
      chk({7'h00, activeOn}, 8'h01);
      cyc(50);
      chk({7'h00, activeOn}, 8'h00);
      chk({4'h0, stepCode}, 8'h00);
    end
    $display("program test done");
    host_u.pulses(3, 30, 30);
    cyc(ST + 8 * SC + 40);
    host_u.drive(1'b0, 5);
    host_u.drive(1'b1, 30);
    chkOn(3);
    host_u.pulses(1, 30, 30);
    cyc(15);
    chkOn(4);
    $display("step test done");
    underVoltage = 1'b1;
    cyc(10);
    chk(currentLevel, 8'h00);
    underVoltage = 1'b0;
    cyc(10);
    chkOn(4);
    ledShort = 1'b1;
    cyc(10);
    chk({7'h00, senseOn}, 8'h01);
    ledShort = 1'b0;
    cyc(10);
    chkOn(4);
    overTemp = 1'b1;
    cyc(10);
    chk({7'h00, thermalTrip}, 8'h01);
    overTemp = 1'b0;
    cyc(10);
    chk(8'(driveMode), 8'(OUT_OFF));
    host_u.drive(1'b0, SD + 30);
    chk({7'h00, thermalTrip}, 8'h00);
    host_u.pulses(2, 30, 30);
    cyc(ST + 8 * SC + 40);
    chkOn(2);
    $display("fault test done");
    summarize();
  end
endmodule
bind pulse_count_led_current_ctrl led_ctrl_monitor #(.SHDN_CYC(SHDN_CYC), .START_CYC(START_CYC))
  mon_u (.clk_sys, .rst_n, .ctrlPin, .underVoltage, .activeOn, .stepCode, .rampStep,
  .currentLevel, .senseOn, .thermalTrip, .driveMode);
`default_nettype wire
